/* File: sfpa_consts.vh */
// constants for the serial flash protect and addressing front end
`ifndef SFPA_CONSTS_VH
`define SFPA_CONSTS_VH
// command opcodes
`define OP_WLSET    8'h06
`define OP_WLCLR    8'h04
`define OP_SR_RD    8'h05
`define OP_SR_WR    8'h01
`define OP_RD       8'h03
`define OP_RD4      8'h13
`define OP_PP       8'h02
`define OP_PP4      8'h12
`define OP_SE       8'h20
`define OP_SE4      8'h21
`define OP_BE       8'hD8
`define OP_BE4      8'hDC
`define OP_OTP_IN   8'hB1
`define OP_OTP_OUT  8'hC1
`define OP_SCUR_RD  8'h2B
`define OP_SCUR_WR  8'h2F
`define OP_WIDE_IN  8'hB7
`define OP_WIDE_OUT 8'hE9
`define OP_SEG_WR   8'hC5
`define OP_SEG_RD   8'hC8
// opcode classes
`define CL_BAD      3'h0
`define CL_CTRL     3'h1
`define CL_READ     3'h2
`define CL_PROG     3'h3
`define CL_ERASE    3'h4
`define CL_DATA     3'h5
`define CL_REG      3'h6
// kinds handed to the array back end
`define K_PROG      3'h0
`define K_SE        3'h1
`define K_BE        3'h2
`define K_STATUS    3'h3
// array organisation and protection
`define NUM_BLOCKS  10'h200
`define LAST_BLOCK  9'h1FF
`define PROT_ALL_LV 4'hA
`define SERIAL_END  9'h010
`define ALEN_SHORT  3'h3
`define ALEN_WIDE   3'h4
`endif

/* File: sfpa_top.v */
// serial flash front end: framing, protection, secure area and addressing
//
// Notes on behaviour
// - bottom select, levels 1..9 protect lowest 2^(level-1) blocks; level 0 none.
// - levels 10..15 protect all 512 blocks regardless of select bit.
// - top select, levels 1..9 protect highest 2^(level-1) blocks from 511 down.
// - secure area programmed via enter command, normal program, exit command.
// - security register bit 0 reports the factory lock.
// - security register write command sets customer lock bit 1.
// - once locked, lock and secure contents never change again.
// - while secure-area mode is active, main array access is refused.
// - secure offsets 000..00F hold serial number; 010..1FF are customer area.
// - array spans 0..1FFFFFF; blocks 0 and 511 lock per 4KB sector.
// - invalid command drops to standby until next select fall; output high-z.
// - valid command keeps device active until next select rise.
// - sample input on clock rise, shift output on fall; modes 0 and 3.
// - read-type commands may end after any output bit.
// - write-type commands must end on a byte boundary or are rejected.
// - during busy, array accesses are ignored and do not disturb it.
// - wide-address enter sets the wide flag; then all addresses are 32 bit.
// - segment bit 0 picks the 128Mb half for 3-byte addresses.
// - dedicated 4-byte opcodes take 32 address bits without wide mode.
// - in wide mode the segment bit is ignored.
// - continuous read across segments leaves segment register unchanged.
// - write latch must be set before program, erase, status or lock writes are accepted; segment writes need none.
`default_nettype none
`include "sfpa_consts.vh"
module sfpa_top #(
  parameter ADDR_W = 25,
  parameter BUF_W  = 37
) (
  input  wire              clock,
  input  wire              rst_n,
  input  wire              cs_n_pin,
  input  wire              sclk_pin,
  input  wire              si_pin,
  input  wire [3:0]        protect_level_bits,
  input  wire              top_bottom_sel,
  input  wire              busy,
  input  wire              factory_lock,
  input  wire [7:0]        mem_rd_data,
  input  wire              cmd_ready,
  output reg               so,
  output reg               so_oe,
  output reg  [ADDR_W-1:0] mem_rd_addr,
  output reg               mem_rd_otp,
  output reg               cmd_valid,
  output reg  [2:0]        cmd_kind,
  output reg               cmd_otp,
  output reg  [ADDR_W-1:0] cmd_addr,
  output reg  [7:0]        cmd_data,
  output reg               cmd_rejected,
  output reg               write_enable_latch_flag,
  output reg               wide_address_flag,
  output reg               segment_select_reg,
  output reg               secure_area_active,
  output reg               customer_lock,
  output reg  [12:0]       lock_unit
);

localparam ST_IDLE = 3'h0;
localparam ST_OP   = 3'h1;
localparam ST_ADDR = 3'h2;
localparam ST_DIN  = 3'h3;
localparam ST_DONE = 3'h4;
localparam ST_OUT  = 3'h5;
localparam ST_IGN  = 3'h6;

////////////////////////////////////////////////////////////////////////////////
function [2:0] op_class;
  input [7:0] op;
  begin
    if (op == `OP_WLSET || op == `OP_WLCLR || op == `OP_OTP_IN || op == `OP_OTP_OUT ||
        op == `OP_SCUR_WR || op == `OP_WIDE_IN || op == `OP_WIDE_OUT)
      op_class = `CL_CTRL;
    else if (op == `OP_RD || op == `OP_RD4)
      op_class = `CL_READ;
    else if (op == `OP_PP || op == `OP_PP4)
      op_class = `CL_PROG;
    else if (op == `OP_SE || op == `OP_SE4 || op == `OP_BE || op == `OP_BE4)
      op_class = `CL_ERASE;
    else if (op == `OP_SR_WR || op == `OP_SEG_WR)
      op_class = `CL_DATA;
    else if (op == `OP_SR_RD || op == `OP_SCUR_RD || op == `OP_SEG_RD)
      op_class = `CL_REG;
    else
      op_class = `CL_BAD;
  end
endfunction

function is4b;
  input [7:0] op;
  begin
    is4b = op == `OP_RD4 || op == `OP_PP4 || op == `OP_SE4 || op == `OP_BE4;
  end
endfunction

function [ADDR_W-1:0] eff_addr;
  input [31:0] raw;
  input        four;
  input        seg;
  input        otp;
  begin
    if (otp)
      eff_addr = {16'h0000, raw[8:0]};
    else if (four)
      eff_addr = raw[ADDR_W-1:0];
    else
      eff_addr = {seg, raw[23:0]};
  end
endfunction

function prot;
  input [ADDR_W-1:0] a;
  input [3:0]        lv;
  input              tb;
  reg   [9:0]        blk;
  reg   [9:0]        n;
  begin
    blk = {1'b0, a[24:16]};
    n = 10'h001 << (lv - 4'h1);
    if (lv == 4'h0)
      prot = 1'b0;
    else if (lv >= `PROT_ALL_LV)
      prot = 1'b1;
    else if (tb)
      prot = blk < n;
    else
      prot = blk >= (`NUM_BLOCKS - n);
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
reg              rst_m, rst_s;
reg              cs_m, cs_s, cs_d;
reg              ck_m, ck_s, ck_d;
reg              si_m, si_s;
reg [2:0]        state;
reg [2:0]        bitcnt;
reg [5:0]        byte_cnt;
reg [6:0]        shreg;
reg [7:0]        opcode;
reg [31:0]       addr_raw;
reg [7:0]        data_b;
reg [2:0]        alen;
reg [2:0]        obit;
reg [6:0]        out_sh;
reg              push_req;
reg [BUF_W-1:0]  push_ent;
reg              tail_v;
reg [BUF_W-1:0]  tail;
reg [7:0]        src;
reg [5:0]        need;

wire [7:0]        nb      = {shreg, si_s};
wire [2:0]        cls     = op_class(opcode);
wire              four    = alen == `ALEN_WIDE;
wire [ADDR_W-1:0] ea      = eff_addr(addr_raw, four, segment_select_reg, secure_area_active);
wire              ck_rise = ck_s & ~ck_d;
wire              ck_fall = ~ck_s & ck_d;
wire              cs_fall = ~cs_s & cs_d;
wire              cs_rise = cs_s & ~cs_d;
wire              room    = ~tail_v & ~push_req;
wire              pop     = cmd_valid & cmd_ready;
wire              otp_lck = factory_lock | customer_lock;
wire              wr_ok   = write_enable_latch_flag & ~busy & room;

////////////////////////////////////////////////////////////////////////////////
// reset release and pin synchronisers
always @(posedge clock or negedge rst_n) begin
  if (!rst_n) begin
    rst_m <= 1'b0;
    rst_s <= 1'b0;
  end else begin
    rst_m <= 1'b1;
    rst_s <= rst_m;
  end
end

always @(posedge clock or negedge rst_s) begin
  if (!rst_s) begin
    cs_m <= 1'b1;
    cs_s <= 1'b1;
    cs_d <= 1'b1;
    ck_m <= 1'b0;
    ck_s <= 1'b0;
    ck_d <= 1'b0;
    si_m <= 1'b0;
    si_s <= 1'b0;
  end else begin
    cs_m <= cs_n_pin;
    cs_s <= cs_m;
    cs_d <= cs_s;
    ck_m <= sclk_pin;
    ck_s <= ck_m;
    ck_d <= ck_s;
    si_m <= si_pin;
    si_s <= si_m;
  end
end

////////////////////////////////////////////////////////////////////////////////
// output byte source and exact frame length per class
always @* begin
  if (opcode == `OP_SR_RD)
    src = {2'b00, protect_level_bits, write_enable_latch_flag, busy};
  else if (opcode == `OP_SCUR_RD)
    src = {6'h00, customer_lock, factory_lock};
  else if (opcode == `OP_SEG_RD)
    src = {7'h00, segment_select_reg};
  else
    src = mem_rd_data;
  case (cls)
    `CL_CTRL:  need = 6'h01;
    `CL_ERASE: need = {3'h0, alen} + 6'h01;
    `CL_PROG:  need = {3'h0, alen} + 6'h02;
    `CL_DATA:  need = 6'h02;
    default:   need = 6'h00;
  endcase
end

////////////////////////////////////////////////////////////////////////////////
// command framing, control flags and commit
always @(posedge clock or negedge rst_s) begin
  if (!rst_s) begin
    state                   <= ST_IDLE;
    bitcnt                  <= 3'h0;
    byte_cnt                <= 6'h00;
    shreg                   <= 7'h00;
    opcode                  <= 8'h00;
    addr_raw                <= 32'h0000_0000;
    data_b                  <= 8'h00;
    alen                    <= `ALEN_SHORT;
    obit                    <= 3'h0;
    out_sh                  <= 7'h00;
    so                      <= 1'b0;
    so_oe                   <= 1'b0;
    mem_rd_addr             <= {ADDR_W{1'b0}};
    mem_rd_otp              <= 1'b0;
    cmd_rejected            <= 1'b0;
    write_enable_latch_flag <= 1'b0;
    wide_address_flag       <= 1'b0;
    segment_select_reg      <= 1'b0;
    secure_area_active      <= 1'b0;
    customer_lock           <= 1'b0;
    lock_unit               <= 13'h0000;
    push_req                <= 1'b0;
    push_ent                <= {BUF_W{1'b0}};
  end else begin
    push_req     <= 1'b0;
    cmd_rejected <= 1'b0;
    if (cs_fall) begin
      state    <= ST_OP;
      bitcnt   <= 3'h0;
      byte_cnt <= 6'h00;
      so_oe    <= 1'b0;
    end else if (cs_rise) begin
      state <= ST_IDLE;
      so_oe <= 1'b0;
      if (state == ST_DONE) begin
        if (bitcnt != 3'h0 || byte_cnt != need) begin
          cmd_rejected <= 1'b1;
        end else if (opcode == `OP_WLSET) begin
          write_enable_latch_flag <= 1'b1;
        end else if (opcode == `OP_WLCLR) begin
          write_enable_latch_flag <= 1'b0;
        end else if (opcode == `OP_OTP_IN) begin
          secure_area_active <= 1'b1;
        end else if (opcode == `OP_OTP_OUT) begin
          secure_area_active <= 1'b0;
        end else if (opcode == `OP_WIDE_IN) begin
          wide_address_flag <= 1'b1;
        end else if (opcode == `OP_WIDE_OUT) begin
          wide_address_flag <= 1'b0;
        end else if (opcode == `OP_SEG_WR) begin
          segment_select_reg <= data_b[0];
        end else if (opcode == `OP_SCUR_WR) begin
          if (write_enable_latch_flag && !busy) begin
            customer_lock           <= 1'b1;
            write_enable_latch_flag <= 1'b0;
          end else begin
            cmd_rejected <= 1'b1;
          end
        end else if (opcode == `OP_SR_WR) begin
          if (wr_ok) begin
            push_req                <= 1'b1;
            push_ent                <= {`K_STATUS, 1'b0, {ADDR_W{1'b0}}, data_b};
            write_enable_latch_flag <= 1'b0;
          end else begin
            cmd_rejected <= 1'b1;
          end
        end else if (cls == `CL_PROG) begin
          // secure area writes need an open lock and stay off the serial number
          if (wr_ok && (secure_area_active ? (!otp_lck && ea[8:0] >= `SERIAL_END)
                        : !prot(ea, protect_level_bits, top_bottom_sel))) begin
            push_req                <= 1'b1;
            push_ent                <= {`K_PROG, secure_area_active, ea, data_b};
            write_enable_latch_flag <= 1'b0;
            lock_unit               <= (ea[24:16] == 9'h000 || ea[24:16] == `LAST_BLOCK) ?
                                       ea[24:12] : {ea[24:16], 4'h0};
          end else begin
            cmd_rejected <= 1'b1;
          end
        end else if (cls == `CL_ERASE) begin
          if (wr_ok && !secure_area_active &&
              !prot(ea, protect_level_bits, top_bottom_sel)) begin
            push_req                <= 1'b1;
            push_ent                <= {(opcode == `OP_SE || opcode == `OP_SE4) ? `K_SE : `K_BE,
                                        1'b0, ea, 8'h00};
            write_enable_latch_flag <= 1'b0;
            lock_unit               <= (ea[24:16] == 9'h000 || ea[24:16] == `LAST_BLOCK) ?
                                       ea[24:12] : {ea[24:16], 4'h0};
          end else begin
            cmd_rejected <= 1'b1;
          end
        end
      end
    end else if (!cs_s && ck_rise && state != ST_OUT && state != ST_IGN && state != ST_IDLE) begin
      shreg  <= {shreg[5:0], si_s};
      bitcnt <= bitcnt + 3'h1;
      if (bitcnt == 3'h7) begin
        if (byte_cnt != 6'h3F)
          byte_cnt <= byte_cnt + 6'h01;
        if (state == ST_OP) begin
          opcode <= nb;
          alen   <= (wide_address_flag || is4b(nb)) ? `ALEN_WIDE : `ALEN_SHORT;
          obit   <= 3'h0;
          case (op_class(nb))
            `CL_BAD:  state <= ST_IGN;
            `CL_CTRL: state <= ST_DONE;
            `CL_DATA: state <= ST_DIN;
            `CL_REG:  state <= ST_OUT;
            default:  state <= ST_ADDR;
          endcase
        end else if (state == ST_ADDR) begin
          addr_raw <= {addr_raw[23:0], nb};
          if (byte_cnt == {3'h0, alen}) begin
            if (cls == `CL_READ) begin
              // a read while busy must not touch the array
              state       <= busy ? ST_IGN : ST_OUT;
              mem_rd_otp  <= secure_area_active;
              mem_rd_addr <= eff_addr({addr_raw[23:0], nb}, four, segment_select_reg,
                                      secure_area_active);
            end else begin
              state <= (cls == `CL_PROG) ? ST_DIN : ST_DONE;
            end
          end
        end else if (state == ST_DIN) begin
          data_b <= nb;
          state  <= ST_DONE;
        end
      end
    end else if (!cs_s && ck_fall && state == ST_OUT) begin
      so_oe <= 1'b1;
      obit  <= obit + 3'h1;
      if (obit == 3'h0) begin
        so     <= src[7];
        out_sh <= src[6:0];
        if (cls == `CL_READ) begin
          // wraps inside the secure area; the segment bit never follows a crossing
          if (mem_rd_otp)
            mem_rd_addr <= {16'h0000, mem_rd_addr[8:0] + 9'h001};
          else
            mem_rd_addr <= mem_rd_addr + {{(ADDR_W-1){1'b0}}, 1'b1};
        end
      end else begin
        so     <= out_sh[6];
        out_sh <= {out_sh[5:0], 1'b0};
      end
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// two-entry command buffer; a full buffer makes the commit reject
always @(posedge clock or negedge rst_s) begin
  if (!rst_s) begin
    cmd_valid <= 1'b0;
    cmd_kind  <= 3'h0;
    cmd_otp   <= 1'b0;
    cmd_addr  <= {ADDR_W{1'b0}};
    cmd_data  <= 8'h00;
    tail_v    <= 1'b0;
    tail      <= {BUF_W{1'b0}};
  end else if (pop) begin
    if (tail_v) begin
      {cmd_kind, cmd_otp, cmd_addr, cmd_data} <= tail;
      tail_v <= push_req;
      tail   <= push_ent;
    end else if (push_req) begin
      {cmd_kind, cmd_otp, cmd_addr, cmd_data} <= push_ent;
    end else begin
      cmd_valid <= 1'b0;
    end
  end else if (push_req) begin
    if (!cmd_valid) begin
      {cmd_kind, cmd_otp, cmd_addr, cmd_data} <= push_ent;
      cmd_valid <= 1'b1;
    end else begin
      tail   <= push_ent;
      tail_v <= 1'b1;
    end
  end
end

endmodule
`default_nettype wire

/* File: sfpa_chk_asserts.sv */
// concurrent checks on the ports of the serial flash front end
`default_nettype none
`include "sfpa_consts.vh"
module sfpa_chk #(
  parameter ADDR_W = 25
) (
  input wire logic              clock,
  input wire logic              rst_n,
  input wire logic              cs_n_pin,
  input wire logic              busy,
  input wire logic              factory_lock,
  input wire logic [3:0]        protect_level_bits,
  input wire logic              top_bottom_sel,
  input wire logic              so_oe,
  input wire logic              cmd_valid,
  input wire logic [2:0]        cmd_kind,
  input wire logic              cmd_otp,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic              cmd_rejected,
  input wire logic              segment_select_reg,
  input wire logic              customer_lock,
  input wire logic [12:0]       lock_unit
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  logic [9:0] n_prot;
  logic [8:0] blk;
  logic       arr;
  // levels from ten upward cover the whole array, so clamp before the shift overflows
  assign n_prot = (protect_level_bits >= `PROT_ALL_LV) ? 10'h200 :
                  (protect_level_bits == 4'h0) ? 10'h000 : (10'h001 << (protect_level_bits - 4'h1));
  assign blk = cmd_addr[24:16];
  assign arr = !cmd_otp && cmd_kind != `K_STATUS;
  ////////////////////////////////////////
  AST_REJ_PULSE: assert property (cmd_rejected |=> !cmd_rejected)
    else $error("reject flag held longer than one cycle");
  AST_OE_IDLE: assert property (cs_n_pin [*6] |-> !so_oe)
    else $error("serial output driven while deselected");
  AST_BUSY_NO_PUSH: assert property (busy [*8] |-> !$rose(cmd_valid))
    else $error("command queued while busy");
  AST_CUST_STICKY: assert property (customer_lock |=> customer_lock)
    else $error("customer lock cleared");
  AST_OTP_PROG: assert property ($rose(cmd_valid) && cmd_otp |->
    cmd_addr[8:0] >= `SERIAL_END && !customer_lock && !factory_lock)
    else $error("secure program into locked or serial region");
  AST_PROT_BOTTOM: assert property ($rose(cmd_valid) && arr && top_bottom_sel |->
    {1'b0, blk} >= n_prot)
    else $error("bottom protected block changed");
  AST_PROT_TOP: assert property ($rose(cmd_valid) && arr && !top_bottom_sel |->
    {1'b0, blk} < 10'h200 - n_prot)
    else $error("top protected block changed");
  AST_PROT_ALL: assert property ($rose(cmd_valid) && arr |-> protect_level_bits < `PROT_ALL_LV)
    else $error("array change under full protection");
  AST_SEG_HELD: assert property (so_oe |-> $stable(segment_select_reg))
    else $error("segment changed during read");
  AST_LOCK_UNIT: assert property ($rose(cmd_valid) && arr |->
    lock_unit == ((blk == 9'h000 || blk == `LAST_BLOCK) ? cmd_addr[24:12] : {blk, 4'h0}))
    else $error("wrong lock unit");
endmodule
bind sfpa_top sfpa_chk #(.ADDR_W(ADDR_W)) i_chk (
  .clock(clock), .rst_n(rst_n), .cs_n_pin(cs_n_pin), .busy(busy),
  .factory_lock(factory_lock), .protect_level_bits(protect_level_bits),
  .top_bottom_sel(top_bottom_sel), .so_oe(so_oe), .cmd_valid(cmd_valid),
  .cmd_kind(cmd_kind), .cmd_otp(cmd_otp), .cmd_addr(cmd_addr),
  .cmd_rejected(cmd_rejected), .segment_select_reg(segment_select_reg),
  .customer_lock(customer_lock), .lock_unit(lock_unit)
);
`default_nettype wire

/* File: sfpa_host.sv */
// host side serial controller model for the flash link
`default_nettype none
module sfpa_host (
  input  wire logic clock,
  input  wire logic so,
  input  wire logic so_oe,
  output var  logic cs_n_pin,
  output var  logic sclk_pin,
  output var  logic si_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        cpol = 1'b0;
  logic [63:0] rx;
  logic        oe_seen;
  initial begin
    cs_n_pin = 1'b1;
    sclk_pin = 1'b0;
    si_pin = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // nb bits of d go out msb first, then nr bits are clocked in
  task automatic frame(input logic [63:0] d, input int nb, input int nr);
    sclk_pin <= cpol;
    tick(2);
    cs_n_pin <= 1'b0;
    oe_seen = 1'b0;
    tick(4);
    for (int i = 0; i < nb + nr; i++) begin
      sclk_pin <= 1'b0;
      si_pin <= (i < nb) ? d[63-i] : ~si_pin;
      tick(4);
      sclk_pin <= 1'b1;
      tick(2);
      // a released output reads as the inverse, so a stale bit cannot pass
      rx = {rx[62:0], so_oe ? so : ~so};
      oe_seen |= so_oe;
      tick(2);
    end
    sclk_pin <= cpol;
    si_pin <= ~si_pin;
    tick(4);
    cs_n_pin <= 1'b1;
    tick(8);
  endtask
endmodule
`default_nettype wire

/* File: serial_flash_protect_addressing_tb.sv */
// self-checking bench for the serial flash front end
`default_nettype none
`include "sfpa_consts.vh"
module serial_flash_protect_addressing_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  protect_level_bits = 4'h0;
  logic        top_bottom_sel = 1'b1;
  logic        busy = 1'b0;
  logic        factory_lock = 1'b0;
  logic [7:0]  mem_rd_data = 8'h00;
  logic        cmd_ready = 1'b0;
  logic        cs_n_pin, sclk_pin, si_pin, so, so_oe, mem_rd_otp, cmd_valid, cmd_otp;
  logic        cmd_rejected, write_enable_latch_flag, wide_address_flag;
  logic        segment_select_reg, secure_area_active, customer_lock;
  logic [24:0] mem_rd_addr, cmd_addr;
  logic [2:0]  cmd_kind;
  logic [7:0]  cmd_data;
  logic [12:0] lock_unit;
  logic [39:0] row;
  int          errors = 0;
  int          n_checks = 0;
  int          n_rej = 0;
  int          n0;
  // level, {tb, pushed}, 4-byte address
  logic [39:0] rows [14] = '{40'h03_0000_0000, 40'h12_0000_F000, 40'h13_0001_0000,
    40'h32_0003_F000, 40'h33_0004_0000, 40'h92_00FF_F000, 40'h93_0100_0000,
    40'h10_01FF_0000, 40'h11_01FE_F000, 40'h91_00FF_F000, 40'h90_0100_0000,
    40'hA2_0000_0000, 40'hF0_0080_0000, 40'h01_01FF_5000};
  sfpa_top i_dut (
    .clock(clock), .rst_n(rst_n), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .si_pin(si_pin),
    .protect_level_bits(protect_level_bits), .top_bottom_sel(top_bottom_sel), .busy(busy),
    .factory_lock(factory_lock), .mem_rd_data(mem_rd_data), .cmd_ready(cmd_ready), .so(so),
    .so_oe(so_oe), .mem_rd_addr(mem_rd_addr), .mem_rd_otp(mem_rd_otp), .cmd_valid(cmd_valid),
    .cmd_kind(cmd_kind), .cmd_otp(cmd_otp), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .cmd_rejected(cmd_rejected), .write_enable_latch_flag(write_enable_latch_flag),
    .wide_address_flag(wide_address_flag), .segment_select_reg(segment_select_reg),
    .secure_area_active(secure_area_active), .customer_lock(customer_lock),
    .lock_unit(lock_unit)
  );
  sfpa_host i_host (
    .clock(clock), .so(so), .so_oe(so_oe), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin),
    .si_pin(si_pin)
  );
  always #10 clock = ~clock;
  always @(posedge clock) mem_rd_data <= mem_rd_addr[7:0] ^ 8'hA5;
  always @(posedge clock) if (cmd_rejected === 1'b1) n_rej <= n_rej + 1;
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic f(input logic [63:0] d, input int nb, input int nr);
    i_host.frame(d, nb, nr);
  endtask
  task automatic wl;
    f({`OP_WLSET, 56'h0}, 8, 0);
  endtask
  task automatic pop;
    cmd_ready <= 1'b1;
    @(posedge clock);
    cmd_ready <= 1'b0;
    @(posedge clock);
  endtask
  function automatic logic [12:0] unit(input logic [31:0] a);
    return (a[24:16] == 9'h000 || a[24:16] == `LAST_BLOCK) ? a[24:12] : {a[24:16], 4'h0};
  endfunction
  ////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge clock);
    errors++;
    report_and_stop();
  end
  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    repeat (6) @(posedge clock);
    chk({cmd_valid, so_oe, write_enable_latch_flag, wide_address_flag, segment_select_reg,
         secure_area_active, customer_lock, lock_unit}, 32'h0000_0000);
    for (int r = 0; r < 14; r++) begin
      row = rows[r];
      protect_level_bits <= row[39:36];
      top_bottom_sel <= row[33];
      wl();
      f({`OP_SE4, row[31:0], 24'h0}, 40, 0);
      chk(cmd_valid, row[32]);
      if (row[32]) begin
        chk({cmd_kind, cmd_addr}, {`K_SE, row[24:0]});
        chk(lock_unit, unit(row[31:0]));
        pop();
      end
    end
    protect_level_bits <= 4'h0;
    n0 = n_rej;
    f({`OP_SE4, 32'h0, 24'h0}, 40, 0);
    wl();
    f({`OP_SE4, 32'h0002_0000, 24'h0}, 43, 0);
    busy <= 1'b1;
    f({`OP_SE4, 32'h0003_0000, 24'h0}, 40, 0);
    f({`OP_RD, 24'h00_0010, 32'h0}, 32, 8);
    chk(i_host.oe_seen, 0);
    f({`OP_SR_RD, 56'h0}, 8, 8);
    chk(i_host.rx[7:0], 8'h03);
    busy <= 1'b0;
    chk(n_rej - n0, 3);
    chk(cmd_valid, 0);
    for (int m = 0; m < 2; m++) begin
      i_host.cpol = m[0];
      f({`OP_RD, 24'h00_0010, 32'h0}, 32, 12);
      chk(i_host.rx[11:0], ({8'h10, 8'h11} ^ 16'hA5A5) >> 4);
      chk(i_host.oe_seen, 1);
    end
    f({8'hFF, 56'h0}, 8, 8);
    chk(i_host.oe_seen, 0);
    f({`OP_SEG_WR, 8'h01, 48'h0}, 16, 0);
    chk(segment_select_reg, 1);
    f({`OP_RD, 24'hFF_FFFF, 32'h0}, 32, 16);
    chk({segment_select_reg, i_host.rx[15:0]}, {1'b1, 16'h5AA5});
    f({`OP_SEG_RD, 56'h0}, 8, 8);
    chk(i_host.rx[7:0], 8'h01);
    wl();
    f({`OP_SE, 24'h00_2000, 32'h0}, 32, 0);
    chk(cmd_addr, 25'h100_2000);
    pop();
    wl();
    f({`OP_WIDE_IN, 56'h0}, 8, 0);
    chk(wide_address_flag, 1);
    wl();
    f({`OP_SE, 32'h0000_3000, 24'h0}, 40, 0);
    chk(cmd_addr, 25'h000_3000);
    pop();
    f({`OP_WIDE_OUT, 56'h0}, 8, 0);
    f({`OP_OTP_IN, 56'h0}, 8, 0);
    chk(secure_area_active, 1);
    f({`OP_RD, 24'h00_0021, 32'h0}, 32, 8);
    chk({mem_rd_otp, i_host.rx[7:0], mem_rd_addr[15:0]}, {1'b1, 8'h84, 16'h0022});
    n0 = n_rej;
    wl();
    f({`OP_PP, 24'h00_0005, 8'h3C, 24'h0}, 40, 0);
    wl();
    f({`OP_SE, 24'h00_0000, 32'h0}, 32, 0);
    chk(n_rej - n0, 2);
    wl();
    f({`OP_PP, 24'h00_0020, 8'hAB, 24'h0}, 40, 0);
    chk({cmd_kind, cmd_otp, cmd_addr[8:0], cmd_data}, {`K_PROG, 1'b1, 9'h020, 8'hAB});
    pop();
    f({`OP_OTP_OUT, 56'h0}, 8, 0);
    chk(secure_area_active, 0);
    wl();
    f({`OP_SCUR_WR, 56'h0}, 8, 0);
    chk(customer_lock, 1);
    factory_lock <= 1'b1;
    f({`OP_SCUR_RD, 56'h0}, 8, 8);
    chk(i_host.rx[7:0], 8'h03);
    f({`OP_OTP_IN, 56'h0}, 8, 0);
    n0 = n_rej;
    wl();
    f({`OP_PP, 24'h00_0030, 8'h11, 24'h0}, 40, 0);
    chk(cmd_valid, 0);
    chk(n_rej - n0, 1);
    f({`OP_OTP_OUT, 56'h0}, 8, 0);
    n0 = n_rej;
    for (int i = 0; i < 3; i++) begin
      wl();
      f({`OP_PP, 24'h02_0000, i[7:0], 24'h0}, 40, 0);
    end
    chk(n_rej - n0, 1);
    chk(cmd_data, 8'h00);
    pop();
    chk(cmd_data, 8'h01);
    pop();
    chk(cmd_valid, 0);
    f({`OP_WLCLR, 56'h0}, 8, 0);
    chk(write_enable_latch_flag, 0);
    f({`OP_SR_WR, 8'h5A, 48'h0}, 16, 0);
    chk(cmd_valid, 0);
    wl();
    f({`OP_SR_WR, 8'h5A, 48'h0}, 16, 0);
    chk({cmd_kind, cmd_data}, {`K_STATUS, 8'h5A});
    pop();
    wl();
    f({`OP_BE4, 32'h0005_0000, 24'h0}, 40, 0);
    chk({cmd_kind, cmd_addr}, {`K_BE, 25'h005_0000});
    pop();
    report_and_stop();
  end
endmodule
`default_nettype wire
